/* cmcap_top.sv */
`timescale 1ns/1ps
module cmcap_top #(
  parameter longint unsigned SAVE_PERIOD_CYC = cmcap_pkg::SAVE_PERIOD_CYC
) (
  input wire logic clock_i,                // core clock, 200 MHz
  input wire logic resetn_i,               // sync reset, active low
  input wire logic param_wr_i,             // parameter byte write strobe
  input wire logic [4:0] param_addr_i,     // parameter byte index
  input wire logic [7:0] param_wdata_i,    // parameter write data
  output logic [7:0] param_rdata_o,        // parameter read data, one cycle late
  input wire logic temp_valid_i,           // new temperature reading
  input wire logic [7:0] temp_deg_i,       // temperature, whole degrees, signed
  input wire logic [9:0] volt_i,           // voltage reading
  input wire logic [15:0] curr_i,          // current reading, signed
  input wire logic [15:0] iavg_i,          // average current, signed
  input wire logic acc_dec_i,              // coulomb count decreased
  input wire logic [15:0] acc_dec_amt_i,   // size of that decrease
  input wire logic learn_valid_i,          // learned health factor ready
  input wire logic [7:0] learn_as_i,       // learned health factor
  input wire logic nv_recall_valid_i,      // stored health factor returned
  input wire logic [7:0] nv_recall_as_i,   // stored health factor
  output logic nv_recall_req_o,            // asking for stored health factor
  output logic nv_save_o,                  // save health factor now
  output logic [7:0] nv_save_as_o,         // health factor to save
  output logic [15:0] full_t_o,            // full at present temperature
  output logic [15:0] ae_t_o,              // active empty at present temperature
  output logic [15:0] se_t_o,              // standby empty at present temperature
  output logic model_valid_o,              // results hold a finished lookup
  output logic [15:0] aged_full_o,         // full scaled by health factor
  output logic [23:0] full_mah_o,          // full at 40 C in mAh
  output logic [7:0] health_factor_o,      // working health factor
  output logic full_v_ok_o,                // voltage above full threshold
  output logic full_i_ok_o,                // average charge below floor, above zero
  output logic empty_v_o,                  // voltage below empty threshold
  output logic empty_i_o                   // discharge above empty threshold
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] shunt_conductance;
    logic [7:0] full_voltage_threshold;
    logic [7:0] full_current_floor;
    logic [7:0] empty_voltage_threshold;
    logic [7:0] empty_discharge_threshold;
    logic [15:0] wear_rated_charge;
    logic [7:0] health_factor;
    logic [15:0] full40;
    logic [7:0] ae40;
    logic [2:0][3:0][7:0] slope;
    logic [7:0] rdata;
    logic start;
    logic [7:0] temp;
    logic [15:0] full_t;
    logic [15:0] ae_t;
    logic [15:0] se_t;
    logic model_valid;
    logic [15:0] aged_full;
    logic [23:0] full_mah;
    logic [21:0] age_cnt;
    logic [63:0] save_cnt;
    logic nv_save;
    logic [7:0] nv_as;
    logic recall_req;
    logic full_v_ok;
    logic full_i_ok;
    logic empty_v;
    logic empty_i;
  } cmcap_state_type;

  cmcap_state_type s_ff;
  cmcap_state_type nxt_s;
  cmcap_lut_if lut ();

  // ----------------------------------------------------------------
  // curve rebuild engine
  // ----------------------------------------------------------------
  cmcap_lookup u_lookup (
    .clock_i (clock_i),
    .resetn_i (resetn_i),
    .lut (lut.eng)
  );

  assign lut.start = s_ff.start;
  assign lut.temp = s_ff.temp;
  assign lut.full_base = cmcap_pkg::FRAC_ONE; // full at 40 C is the unit
  assign lut.ae_base = {4'h0, s_ff.ae40, cmcap_pkg::AE40_PAD};
  assign lut.slope = s_ff.slope;

  // health factor scaling, lsb 2^-7
  function automatic logic [15:0] cmcap_age_scale(input logic [15:0] v, input logic [7:0] a);
    logic [23:0] p;
    p = v * a;
    cmcap_age_scale = p[15+cmcap_pkg::AS_FRAC:cmcap_pkg::AS_FRAC];
  endfunction : cmcap_age_scale

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [21:0] age_sum;
    logic [21:0] age_thr;
    logic [4:0] sidx;
    logic signed [16:0] iae_neg;
    age_sum = '0;
    age_thr = '0;
    sidx = '0;
    iae_neg = '0;
    nxt_s = s_ff;
    nxt_s.start = 1'b0;
    nxt_s.nv_save = 1'b0;

    // rebuild on every new temperature reading
    if (temp_valid_i)
    begin
      nxt_s.start = 1'b1;
      nxt_s.temp = temp_deg_i;
    end
    if (lut.done)
    begin
      nxt_s.full_t = lut.full_t;
      nxt_s.ae_t = lut.ae_t;
      nxt_s.se_t = lut.se_t;
      nxt_s.model_valid = 1'b1;
    end

    // full result scaled by present health factor
    nxt_s.aged_full = cmcap_age_scale(s_ff.full_t, s_ff.health_factor);
    // mVh times mhos gives mAh
    nxt_s.full_mah = s_ff.full40 * s_ff.shunt_conductance;

    // threshold comparisons; voltage lsb is a quarter of 19.52 mV
    nxt_s.full_v_ok = volt_i[9:cmcap_pkg::VOLT_DROP] > s_ff.full_voltage_threshold;
    nxt_s.empty_v = volt_i[9:cmcap_pkg::VOLT_DROP] < s_ff.empty_voltage_threshold;
    // 50 uV floor over a 1.5625 uV current lsb
    nxt_s.full_i_ok = ($signed(iavg_i) > 16'sh0000) &&
      ($signed(iavg_i) < $signed({3'h0, s_ff.full_current_floor, cmcap_pkg::FULL_CURRENT_FLOOR_PAD}));
    // 200 uV per count, discharge is negative current
    iae_neg = -$signed({1'b0, s_ff.empty_discharge_threshold, cmcap_pkg::IAE_PAD, 1'b0});
    iae_neg = iae_neg >>> 1;
    nxt_s.empty_i = $signed({curr_i[15], curr_i}) < iae_neg;

    // aging: partial discharges add up until 32 times rating
    age_thr = {1'b0, s_ff.wear_rated_charge, cmcap_pkg::AGE_PAD};
    if (acc_dec_i)
    begin
      age_sum = s_ff.age_cnt + {6'h00, acc_dec_amt_i};
      // zero rating would decrement on every event, so aging is off then
      if ((s_ff.wear_rated_charge != 16'h0000) && (age_sum >= age_thr))
      begin
        nxt_s.age_cnt = age_sum - age_thr;
        if (s_ff.health_factor > cmcap_pkg::AS_FLOOR)
          nxt_s.health_factor = s_ff.health_factor - 8'h01;
      end
      else
        nxt_s.age_cnt = age_sum;
    end

    // learned capacity overrides the cycle estimate
    if (learn_valid_i)
      nxt_s.health_factor = learn_as_i;

    // power-up recall of the stored health factor
    if (s_ff.recall_req && nv_recall_valid_i)
    begin
      nxt_s.health_factor = nv_recall_as_i;
      nxt_s.recall_req = 1'b0;
    end

    // periodic save, held off until the recall is done
    if (s_ff.recall_req)
      nxt_s.save_cnt = '0;
    else if (s_ff.save_cnt >= SAVE_PERIOD_CYC - 64'd1)
    begin
      nxt_s.save_cnt = '0;
      nxt_s.nv_save = 1'b1;
      nxt_s.nv_as = s_ff.health_factor;
    end
    else
      nxt_s.save_cnt = s_ff.save_cnt + 64'd1;

    // host writes win over internal updates in the same cycle
    if (param_wr_i)
    begin
      unique case (param_addr_i)
        cmcap_pkg::IDX_SHUNT: nxt_s.shunt_conductance = param_wdata_i;
        cmcap_pkg::IDX_FULL_VOLTAGE_THRESHOLD: nxt_s.full_voltage_threshold = param_wdata_i;
        cmcap_pkg::IDX_FULL_CURRENT_FLOOR: nxt_s.full_current_floor = param_wdata_i;
        cmcap_pkg::IDX_VAE: nxt_s.empty_voltage_threshold = param_wdata_i;
        cmcap_pkg::IDX_IAE: nxt_s.empty_discharge_threshold = param_wdata_i;
        cmcap_pkg::IDX_AC_HI: nxt_s.wear_rated_charge[15:8] = param_wdata_i;
        cmcap_pkg::IDX_AC_LO: nxt_s.wear_rated_charge[7:0] = param_wdata_i;
        cmcap_pkg::IDX_AS: nxt_s.health_factor = param_wdata_i;
        cmcap_pkg::IDX_FULL40_HI: nxt_s.full40[15:8] = param_wdata_i;
        cmcap_pkg::IDX_FULL40_LO: nxt_s.full40[7:0] = param_wdata_i;
        cmcap_pkg::IDX_AE40: nxt_s.ae40 = param_wdata_i;
        default:
        begin
          if ((param_addr_i >= cmcap_pkg::IDX_SLOPE_BASE) &&
              (param_addr_i <= cmcap_pkg::IDX_SLOPE_LAST))
          begin
            sidx = param_addr_i - cmcap_pkg::IDX_SLOPE_BASE;
            nxt_s.slope[sidx[3:2]][sidx[1:0]] = param_wdata_i;
          end
        end
      endcase
    end

    // registered read; unmapped indices read zero
    unique case (param_addr_i)
      cmcap_pkg::IDX_SHUNT: nxt_s.rdata = s_ff.shunt_conductance;
      cmcap_pkg::IDX_FULL_VOLTAGE_THRESHOLD: nxt_s.rdata = s_ff.full_voltage_threshold;
      cmcap_pkg::IDX_FULL_CURRENT_FLOOR: nxt_s.rdata = s_ff.full_current_floor;
      cmcap_pkg::IDX_VAE: nxt_s.rdata = s_ff.empty_voltage_threshold;
      cmcap_pkg::IDX_IAE: nxt_s.rdata = s_ff.empty_discharge_threshold;
      cmcap_pkg::IDX_AC_HI: nxt_s.rdata = s_ff.wear_rated_charge[15:8];
      cmcap_pkg::IDX_AC_LO: nxt_s.rdata = s_ff.wear_rated_charge[7:0];
      cmcap_pkg::IDX_AS: nxt_s.rdata = s_ff.health_factor;
      cmcap_pkg::IDX_FULL40_HI: nxt_s.rdata = s_ff.full40[15:8];
      cmcap_pkg::IDX_FULL40_LO: nxt_s.rdata = s_ff.full40[7:0];
      cmcap_pkg::IDX_AE40: nxt_s.rdata = s_ff.ae40;
      default:
      begin
        if ((param_addr_i >= cmcap_pkg::IDX_SLOPE_BASE) &&
            (param_addr_i <= cmcap_pkg::IDX_SLOPE_LAST))
        begin
          sidx = param_addr_i - cmcap_pkg::IDX_SLOPE_BASE;
          nxt_s.rdata = s_ff.slope[sidx[3:2]][sidx[1:0]];
        end
        else
          nxt_s.rdata = cmcap_pkg::BYTE_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      s_ff <= '0;
      s_ff.health_factor <= cmcap_pkg::AS_UNAGED;
      s_ff.nv_as <= cmcap_pkg::AS_UNAGED;
      s_ff.recall_req <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign param_rdata_o = s_ff.rdata;
  assign nv_recall_req_o = s_ff.recall_req;
  assign nv_save_o = s_ff.nv_save;
  assign nv_save_as_o = s_ff.nv_as;
  assign full_t_o = s_ff.full_t;
  assign ae_t_o = s_ff.ae_t;
  assign se_t_o = s_ff.se_t;
  assign model_valid_o = s_ff.model_valid;
  assign aged_full_o = s_ff.aged_full;
  assign full_mah_o = s_ff.full_mah;
  assign health_factor_o = s_ff.health_factor;
  assign full_v_ok_o = s_ff.full_v_ok;
  assign full_i_ok_o = s_ff.full_i_ok;
  assign empty_v_o = s_ff.empty_v;
  assign empty_i_o = s_ff.empty_i;

endmodule : cmcap_top

/* cmcap_pkg.sv */
// Notes on behaviour
// - three capacity curves, full/active empty/standby empty, four segments over 0..40 C.
// - above 40 C each curve holds its 40 C value, zero slope.
// - below 0 C each curve extends with its 0..10 C segment slope.
// - curves are rebuilt at the present temperature in one-degree steps.
// - points normalized to 40 C full; store full mVh and empty fraction; standby zero.
// - per-segment slopes with segment edges fixed at 0, 10, 20, 30, 40 C.
// - shunt conductance byte in mhos multiplies mVh into mAh results.
// - full voltage threshold byte, 19.52 mV per count, compared with voltage readings.
// - full current floor byte, 0 to 12.75 mV sense voltage.
// - empty voltage threshold byte, 19.52 mV per count, detects active empty.
// - empty discharge threshold byte, 200 uV per count, discharge magnitude.
// - wear rated charge is two bytes in coulomb count units, the aging capacity.
// - partial discharges add up toward equivalent full discharges.
// - health factor byte, lsb 2^-7, 80h is unaged, scales capacity down.
// - health factor updated by cycle aging and by the learn function.
// - health factor saved to nonvolatile memory periodically, recalled at power up.
// - discharge advances a counter; at 32 times wear rated charge health drops one.
package cmcap_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'd200_000_000;
  localparam longint unsigned SAVE_PERIOD_S = 64'd16;
  localparam longint unsigned SAVE_PERIOD_CYC = SAVE_PERIOD_S * CLK_HZ;

  // ----------------------------------------------------------------
  // parameter store indices
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_SHUNT = 5'h00;
  localparam logic [4:0] IDX_FULL_VOLTAGE_THRESHOLD = 5'h01;
  localparam logic [4:0] IDX_FULL_CURRENT_FLOOR = 5'h02;
  localparam logic [4:0] IDX_VAE = 5'h03;
  localparam logic [4:0] IDX_IAE = 5'h04;
  localparam logic [4:0] IDX_AC_HI = 5'h05;
  localparam logic [4:0] IDX_AC_LO = 5'h06;
  localparam logic [4:0] IDX_AS = 5'h07;
  localparam logic [4:0] IDX_FULL40_HI = 5'h08;
  localparam logic [4:0] IDX_FULL40_LO = 5'h09;
  localparam logic [4:0] IDX_AE40 = 5'h0A;
  localparam logic [4:0] IDX_SLOPE_BASE = 5'h0B;
  localparam logic [4:0] IDX_SLOPE_LAST = 5'h16;

  // ----------------------------------------------------------------
  // model layout
  // ----------------------------------------------------------------
  localparam int NUM_CURVES = 3;
  localparam int NUM_SEGS = 4;
  localparam int CRV_FULL = 0;
  localparam int CRV_AE = 1;
  localparam int CRV_SE = 2;
  localparam logic signed [8:0] DEG_TOP = 9'sh028;
  localparam logic signed [8:0] DEG_EDGE3 = 9'sh01E;
  localparam logic signed [8:0] DEG_EDGE2 = 9'sh014;
  localparam logic signed [8:0] DEG_EDGE1 = 9'sh00A;
  localparam logic signed [7:0] TEMP_TOP = 8'sh28;
  localparam logic [15:0] FRAC_ONE = 16'h4000;
  localparam logic [3:0] AE40_PAD = 4'h0;
  localparam logic [15:0] SE40_VALUE = 16'h0000;

  // ----------------------------------------------------------------
  // threshold scaling and reset values
  // ----------------------------------------------------------------
  localparam int VOLT_DROP = 2;
  localparam logic [4:0] FULL_CURRENT_FLOOR_PAD = 5'h00;
  localparam logic [6:0] IAE_PAD = 7'h00;
  localparam logic [4:0] AGE_PAD = 5'h00;
  localparam int AS_FRAC = 7;
  localparam logic [7:0] AS_UNAGED = 8'h80;
  localparam logic [7:0] AS_FLOOR = 8'h01;
  localparam logic [7:0] BYTE_RST = 8'h00;

endpackage : cmcap_pkg

/* cmcap_lut_if.sv */
`timescale 1ns/1ps
interface cmcap_lut_if;
  logic start;
  logic signed [7:0] temp;
  logic [15:0] full_base;
  logic [15:0] ae_base;
  logic [2:0][3:0][7:0] slope;
  logic done;
  logic [15:0] full_t;
  logic [15:0] ae_t;
  logic [15:0] se_t;

  modport ctrl (
    output start, temp, full_base, ae_base, slope,
    input done, full_t, ae_t, se_t
  );
  modport eng (
    input start, temp, full_base, ae_base, slope,
    output done, full_t, ae_t, se_t
  );
endinterface : cmcap_lut_if

/* cmcap_lookup.sv */
`timescale 1ns/1ps
module cmcap_lookup (
  input wire logic clock_i,  // core clock
  input wire logic resetn_i, // sync reset, active low
  cmcap_lut_if.eng lut       // lookup request and results
);

  typedef struct packed {
    logic busy;
    logic signed [8:0] deg;
    logic signed [8:0] tgt;
    logic signed [2:0][16:0] val;
    logic done;
    logic [2:0][15:0] res;
  } cmcap_eng_state_type;

  cmcap_eng_state_type s_ff;
  cmcap_eng_state_type nxt_s;

  // values are kept wide and signed; clamped only when published
  function automatic logic [15:0] cmcap_sat(input logic signed [16:0] v);
    if (v < 17'sh00000)
      cmcap_sat = 16'h0000;
    else if (v > $signed({1'b0, cmcap_pkg::FRAC_ONE}))
      cmcap_sat = cmcap_pkg::FRAC_ONE;
    else
      cmcap_sat = v[15:0];
  endfunction : cmcap_sat

  // segment that holds the step from deg down to deg-1
  function automatic logic [1:0] cmcap_seg(input logic signed [8:0] d);
    if (d > cmcap_pkg::DEG_EDGE3)
      cmcap_seg = 2'h3;
    else if (d > cmcap_pkg::DEG_EDGE2)
      cmcap_seg = 2'h2;
    else if (d > cmcap_pkg::DEG_EDGE1)
      cmcap_seg = 2'h1;
    else
      cmcap_seg = 2'h0; // below zero keeps the lowest slope
  endfunction : cmcap_seg

  always_comb
  begin
    logic [1:0] seg;
    seg = cmcap_seg(s_ff.deg);
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (lut.start)
    begin
      nxt_s.busy = 1'b1;
      nxt_s.deg = cmcap_pkg::DEG_TOP;
      // above the model span the top value is held
      if (lut.temp > cmcap_pkg::TEMP_TOP)
        nxt_s.tgt = cmcap_pkg::DEG_TOP;
      else
        nxt_s.tgt = {lut.temp[7], lut.temp};
      nxt_s.val[cmcap_pkg::CRV_FULL] = {1'b0, lut.full_base};
      nxt_s.val[cmcap_pkg::CRV_AE] = {1'b0, lut.ae_base};
      nxt_s.val[cmcap_pkg::CRV_SE] = {1'b0, cmcap_pkg::SE40_VALUE};
    end
    else if (s_ff.busy)
    begin
      if (s_ff.deg == s_ff.tgt)
      begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
        for (int c = 0; c < cmcap_pkg::NUM_CURVES; c++)
          nxt_s.res[c] = cmcap_sat(s_ff.val[c]);
      end
      else
      begin
        // one whole degree per cycle on all three curves
        for (int c = 0; c < cmcap_pkg::NUM_CURVES; c++)
          nxt_s.val[c] = s_ff.val[c] - {{9{lut.slope[c][seg][7]}}, lut.slope[c][seg]};
        nxt_s.deg = s_ff.deg - 9'sh001;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign lut.done = s_ff.done;
  assign lut.full_t = s_ff.res[cmcap_pkg::CRV_FULL];
  assign lut.ae_t = s_ff.res[cmcap_pkg::CRV_AE];
  assign lut.se_t = s_ff.res[cmcap_pkg::CRV_SE];

endmodule : cmcap_lookup

/* cmcap_asserts.sv */
`timescale 1ns/1ps
module cmcap_asserts #(
  parameter longint unsigned SAVE_PERIOD_CYC = 64'd20
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic param_wr_i,
  input wire logic [4:0] param_addr_i,
  input wire logic [7:0] param_wdata_i,
  input wire logic [7:0] param_rdata_o,
  input wire logic temp_valid_i,
  input wire logic [7:0] temp_deg_i,
  input wire logic [9:0] volt_i,
  input wire logic acc_dec_i,
  input wire logic learn_valid_i,
  input wire logic [7:0] learn_as_i,
  input wire logic nv_recall_valid_i,
  input wire logic [7:0] nv_recall_as_i,
  input wire logic nv_recall_req_o,
  input wire logic nv_save_o,
  input wire logic [15:0] full_t_o,
  input wire logic [15:0] se_t_o,
  input wire logic model_valid_o,
  input wire logic [15:0] aged_full_o,
  input wire logic [7:0] health_factor_o,
  input wire logic full_v_ok_o,
  input wire logic empty_v_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  // no other writer of the health factor this cycle
  wire quiet = !param_wr_i && !learn_valid_i && !nv_recall_valid_i;
  sequence s_wr_rd;
    param_wr_i && param_addr_i != 5'h07 && param_addr_i < 5'h17
      ##1 !param_wr_i && $stable(param_addr_i);
  endsequence
  sequence s_top;
    temp_valid_i && $signed(temp_deg_i) >= 8'sh28 ##1 !temp_valid_i [*5];
  endsequence
  param_echo_a:
    assert property (s_wr_rd |=> param_rdata_o == $past(param_wdata_i, 2))
    else $error("stored byte not read back");
  hf_write_a:
    assert property (param_wr_i && param_addr_i == 5'h07 |=> health_factor_o == $past(param_wdata_i))
    else $error("host write to health factor lost");
  recall_load_a:
    assert property (nv_recall_req_o && nv_recall_valid_i && !param_wr_i
      |=> health_factor_o == $past(nv_recall_as_i) && !nv_recall_req_o)
    else $error("recalled health factor not loaded");
  recall_once_a:
    assert property (!nv_recall_req_o |=> !nv_recall_req_o)
    else $error("recall asked again without reset");
  save_pulse_a:
    assert property (nv_save_o |-> !nv_recall_req_o ##1 !nv_save_o)
    else $error("save pulse malformed");
  learn_load_a:
    assert property (learn_valid_i && !param_wr_i && !(nv_recall_req_o && nv_recall_valid_i)
      |=> health_factor_o == $past(learn_as_i))
    else $error("learned health factor not loaded");
  hf_hold_a:
    assert property (quiet && !acc_dec_i |=> $stable(health_factor_o))
    else $error("health factor moved without cause");
  age_step_a:
    assert property (quiet && acc_dec_i |=> health_factor_o == $past(health_factor_o)
      || health_factor_o == $past(health_factor_o) - 8'h01)
    else $error("aging step larger than one");
  top_hold_a:
    assert property (s_top |-> full_t_o == 16'h4000 && se_t_o == 16'h0000 && model_valid_o)
    else $error("curves not at top values");
  aged_scale_a:
    assert property (aged_full_o
      == 16'((24'($past(full_t_o)) * 24'($past(health_factor_o))) >> 7))
    else $error("aged full scaling wrong");
  volt_zero_a:
    assert property (volt_i[9:2] == 8'h00 |=> !full_v_ok_o)
    else $error("full voltage flag at zero volts");
  volt_top_a:
    assert property (volt_i[9:2] == 8'hFF |=> !empty_v_o)
    else $error("empty voltage flag at top volts");
endmodule : cmcap_asserts

bind cmcap_top cmcap_asserts #(.SAVE_PERIOD_CYC(SAVE_PERIOD_CYC)) chk (.*);

/* cmcap_nvmem.sv */
`timescale 1ns/1ps
module cmcap_nvmem #(
  parameter logic [7:0] INIT_AS = 8'h7A,
  parameter int LAG = 4
) (
  input wire logic clock_i,         // core clock
  input wire logic resetn_i,        // sync reset, active low
  input wire logic req_i,           // recall asked
  input wire logic save_i,          // store now
  input wire logic [7:0] save_as_i, // value to store
  output logic valid_o,             // recall answer pulse
  output logic [7:0] as_o,          // recalled value
  output logic [7:0] stored_o       // cell contents
);
  int wait_q = 0;
  initial
  begin
    valid_o = 1'b0;
    as_o = 8'h5A;
    stored_o = INIT_AS;
  end
  // data toggles outside the answer pulse so a stale value never passes
  always @(posedge clock_i)
  begin
    valid_o <= 1'b0;
    as_o <= ~as_o;
    if (save_i)
      stored_o <= save_as_i;
    if (!resetn_i)
      wait_q <= 0;
    else if (req_i && !valid_o)
      wait_q <= wait_q + 1;
    if (resetn_i && req_i && !valid_o && wait_q == LAG)
    begin
      valid_o <= 1'b1;
      as_o <= stored_o;
      wait_q <= 0;
    end
  end
endmodule : cmcap_nvmem

/* cmcap_tb_top.sv */
`timescale 1ns/1ps
module cmcap_tb_top;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic param_wr_i = 1'b0, temp_valid_i = 1'b0, acc_dec_i = 1'b0, learn_valid_i = 1'b0;
  logic [4:0] param_addr_i = 5'h00;
  logic [7:0] param_wdata_i = 8'h00, temp_deg_i = 8'h00, learn_as_i = 8'h00;
  logic [9:0] volt_i = 10'h000;
  logic [15:0] curr_i = 16'h0000, iavg_i = 16'h0000, acc_dec_amt_i = 16'h0000;
  logic nv_recall_valid_i, nv_recall_req_o, nv_save_o, model_valid_o;
  logic full_v_ok_o, full_i_ok_o, empty_v_o, empty_i_o;
  logic [7:0] nv_recall_as_i, nv_save_as_o, param_rdata_o, health_factor_o, stored;
  logic [15:0] full_t_o, ae_t_o, se_t_o, aged_full_o;
  logic [23:0] full_mah_o;
  logic [31:0] seed = 32'h3550;
  int miscompares = 0;
  int cmp_count = 0;
  int r[32];
  int hf = 128, cnt = 0, n, t, c, v[3];
  int tl[12] = '{45, 40, 31, 30, 21, 20, 11, 10, 1, 0, -1, -3};

  always #2.5 clock_i = ~clock_i;

  cmcap_top #(.SAVE_PERIOD_CYC(64'd20)) dut (
    .clock_i, .resetn_i, .param_wr_i, .param_addr_i, .param_wdata_i, .param_rdata_o,
    .temp_valid_i, .temp_deg_i, .volt_i, .curr_i, .iavg_i, .acc_dec_i, .acc_dec_amt_i,
    .learn_valid_i, .learn_as_i, .nv_recall_valid_i, .nv_recall_as_i, .nv_recall_req_o,
    .nv_save_o, .nv_save_as_o, .full_t_o, .ae_t_o, .se_t_o, .model_valid_o, .aged_full_o,
    .full_mah_o, .health_factor_o, .full_v_ok_o, .full_i_ok_o, .empty_v_o, .empty_i_o
  );
  cmcap_nvmem nvm (.clock_i, .resetn_i, .req_i(nv_recall_req_o), .save_i(nv_save_o),
    .save_as_i(nv_save_as_o), .valid_o(nv_recall_valid_i), .as_o(nv_recall_as_i),
    .stored_o(stored));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chkv(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask : chkv
  task automatic chkf(input logic g, input logic e);
    chkv({23'h0, g}, {23'h0, e});
  endtask : chkf
  task automatic wait_recall();
    for (n = 0; n < 50 && nv_recall_req_o !== 1'b0; n++)
      @(negedge clock_i);
    if (nv_recall_req_o !== 1'b0)
    begin
      miscompares++;
      $display("FAIL %0t recall timeout", $time);
      complete_run();
    end
  endtask : wait_recall
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    param_wr_i <= 1'b1;
    param_addr_i <= a;
    param_wdata_i <= d;
    @(posedge clock_i);
    param_wr_i <= 1'b0;
    @(posedge clock_i);
    if (a == 5'h07)
      hf = d;
    else if (a < 5'h17)
      r[a] = d;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    param_addr_i <= a;
    @(posedge clock_i);
    @(negedge clock_i);
    chkv(param_rdata_o, 24'(a == 5'h07 ? hf : (a < 5'h17 ? r[a] : 0)));
    @(posedge clock_i);
  endtask : rd

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    foreach (r[i])
      r[i] = 0;
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    chkv(health_factor_o, 24'h80);
    chkf(nv_recall_req_o, 1'b1);
    chkf(model_valid_o, 1'b0);
    wait_recall();
    hf = 8'h7A;
    chkv(health_factor_o, 24'(hf));
    $display("recall test done");
    @(posedge clock_i);
    for (t = 0; t < 32; t++)
      wr(5'(t), 8'(rnd()));
    for (t = 0; t < 32; t++)
      rd(5'(t));
    $display("register test done");
    for (t = 1; t < 5; t++)
      wr(5'(t), 8'(rnd()));
    for (c = 0; c < 24; c++)
    begin
      t = rnd();
      volt_i <= c == 0 ? 10'h000 : (c == 1 ? 10'h3FF : 10'(t));
      curr_i <= {{2{t[31]}}, t[29:16]};
      iavg_i <= {{3{t[15]}}, t[12:0]};
      @(posedge clock_i);
      @(negedge clock_i);
      chkf(full_v_ok_o, volt_i[9:2] > r[1]);
      chkf(full_i_ok_o, $signed(iavg_i) > 0 && $signed(iavg_i) < r[2] * 32);
      chkf(empty_v_o, volt_i[9:2] < r[3]);
      chkf(empty_i_o, $signed(curr_i) < -(r[4] * 128));
      @(posedge clock_i);
    end
    $display("threshold test done");
    wr(5'h0A, 8'h20);
    for (t = 0; t < 12; t++)
      wr(5'(11 + t), t < 4 ? 8'(rnd() & 63) : 8'(-(rnd() & 63)));
    foreach (tl[i])
    begin
      temp_deg_i <= 8'(tl[i]);
      temp_valid_i <= 1'b1;
      @(posedge clock_i);
      temp_valid_i <= 1'b0;
      v = '{16384, r[10] * 16, 0};
      for (t = 40; t > tl[i]; t--)
        for (c = 0; c < 3; c++)
          v[c] -= $signed(8'(r[11 + c * 4 + (t > 30 ? 3 : t > 20 ? 2 : t > 10 ? 1 : 0)]));
      repeat (45 - (tl[i] > 40 ? 40 : tl[i])) @(posedge clock_i);
      @(negedge clock_i);
      chkv(full_t_o, 24'(v[0]));
      chkv(ae_t_o, 24'(v[1]));
      chkv(se_t_o, 24'(v[2]));
      chkv(aged_full_o, 24'((v[0] * hf) >> 7));
      chkf(model_valid_o, 1'b1);
      @(posedge clock_i);
    end
    chkv(full_mah_o, 24'((r[8] * 256 + r[9]) * r[0]));
    $display("lookup test done");
    wr(5'h05, 8'h00);
    wr(5'h06, 8'h02);
    wr(5'h07, 8'h79);
    for (c = 0; c < 20; c++)
    begin
      if (c == 16)
        wr(5'h07, 8'h01);
      t = c < 16 ? 32'(rnd() & 31) + 1 : 64;
      acc_dec_amt_i <= 16'(t);
      acc_dec_i <= 1'b1;
      @(posedge clock_i);
      acc_dec_i <= 1'b0;
      cnt += t;
      if (cnt >= 64)
      begin
        cnt -= 64;
        if (hf > 1)
          hf--;
      end
      @(negedge clock_i);
      chkv(health_factor_o, 24'(hf));
      @(posedge clock_i);
    end
    learn_as_i <= 8'h76;
    learn_valid_i <= 1'b1;
    @(posedge clock_i);
    learn_valid_i <= 1'b0;
    @(negedge clock_i);
    hf = 8'h76;
    chkv(health_factor_o, 24'(hf));
    $display("aging test done");
    for (t = 0; t < 100 && nv_save_o !== 1'b1; t++)
      @(negedge clock_i);
    chkf(nv_save_o, 1'b1);
    chkv(nv_save_as_o, 24'(hf));
    @(negedge clock_i);
    chkv(stored, 24'(hf));
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    wait_recall();
    chkv(health_factor_o, 24'(hf));
    $display("save test done");
    complete_run();
  end
endmodule : cmcap_tb_top
